// ===== hw/sipc_defines.vh
`ifndef SIPC_DEFINES_VH
`define SIPC_DEFINES_VH
// register word addresses
`define SIPC_ADDR_CLK_CTRL 4'h0
`define SIPC_ADDR_PWR_MODE 4'h1
`define SIPC_ADDR_PWR_CTRL 4'h2
`define SIPC_ADDR_CLK_SEL 4'h3
`define SIPC_ADDR_STATUS 4'h4
`define SIPC_ADDR_RUN_MASK 4'h5
`define SIPC_ADDR_IRQ_ENA 4'h6
// clock control fields
`define SIPC_SUBCLK_SELECT_BIT 0
`define SIPC_MAIN_OSC_STOP_BIT 1
// power save mode select field
`define SIPC_PSM_SELECT_BIT 0
// power save control fields
`define SIPC_STANDBY_TRIGGER_BIT 0
`define SIPC_IRQ_DIS_NMI_BIT 1
`define SIPC_IRQ_DIS_WD2_BIT 2
`define SIPC_IRQ_DIS_MASKABLE_BIT 3
// count clock select fields
`define SIPC_SEL_T1_WATCH_BIT 0
`define SIPC_SEL_WT_SUBCLK_BIT 1
`define SIPC_SEL_BT0_PIN_BIT 2
`define SIPC_SEL_BT0_T1IRQ_BIT 3
`define SIPC_SEL_BT1_PIN_BIT 4
`define SIPC_SEL_BT1_T1IRQ_BIT 5
`define SIPC_SEL_IT1_SUBCLK_BIT 6
`define SIPC_SEL_WD2_SUBCLK_BIT 7
`define SIPC_SEL_CS0_EXT_BIT 8
`define SIPC_SEL_CS1_EXT_BIT 9
`define SIPC_SEL_AS0_PIN_BIT 10
`define SIPC_SEL_RTO_BT_BIT 11
`define SIPC_SEL_RTO_WHICH_BIT 12
// run mask positions
`define SIPC_RUN_CPU 0
`define SIPC_RUN_INTC 1
`define SIPC_RUN_TP 2
`define SIPC_RUN_T0 3
`define SIPC_RUN_T1 4
`define SIPC_RUN_T2 5
`define SIPC_RUN_T3 6
`define SIPC_RUN_BT0 7
`define SIPC_RUN_BT1 8
`define SIPC_RUN_IT0 9
`define SIPC_RUN_IT1 10
`define SIPC_RUN_WT 11
`define SIPC_RUN_WD1 12
`define SIPC_RUN_WD2 13
`define SIPC_RUN_CS0 14
`define SIPC_RUN_CS1 15
`define SIPC_RUN_ATS 16
`define SIPC_RUN_TWS 17
`define SIPC_RUN_AS0 18
`define SIPC_RUN_AS12 19
`define SIPC_RUN_KEY 20
`define SIPC_RUN_ADC 21
`define SIPC_RUN_DAC 22
`define SIPC_RUN_RTO 23
`define SIPC_RUN_DMA 24
`define SIPC_RUN_EBI 25
`define SIPC_RUN_REG 26
`define SIPC_RUN_W 27
// mode codes
`define SIPC_MODE_NORMAL 2'h0
`define SIPC_MODE_SUB 2'h1
`define SIPC_MODE_SUBIDLE 2'h2
// reset values
`define SIPC_CLK_CTRL_RST 2'h0
`define SIPC_CLK_SEL_RST 13'h0000
`define SIPC_SEL_W 13
// entry delay covering the no-op slots after the trigger store
`define SIPC_ENTRY_NOPS 3'h5
`define SIPC_PRIO_W 3
`endif

// ===== hw/sipc_sync2.v
// two-flop synchroniser for asynchronous wake pins
module sipc_sync2 #(
    parameter W = 1
) (
    input wire clk,
    input wire reset,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second
    always @(posedge clk) begin
        if (reset) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // sipc_sync2

// ===== hw/sipc_run_decode.v
`include "sipc_defines.vh"
// combinational run-enable map for every unit
module sipc_run_decode (
    input wire [1:0] mode,
    input wire main_stopped,
    input wire [`SIPC_SEL_W-1:0] sel,
    output reg [`SIPC_RUN_W-1:0] run
);
    reg t1_ok;
    reg sub;
    reg idle;
    reg bt0;
    reg bt1;

    // main stopped only constrains units while in subclock or sub-idle
    always @* begin
        sub = (mode != `SIPC_MODE_NORMAL);
        idle = (mode == `SIPC_MODE_SUBIDLE);
        run = {`SIPC_RUN_W{1'b1}}; // RULE_17
        t1_ok = sel[`SIPC_SEL_T1_WATCH_BIT] &
            (~main_stopped | sel[`SIPC_SEL_WT_SUBCLK_BIT]);
        if (sub) begin
            run[`SIPC_RUN_WD1] = 1'b0; // RULE_16
        end
        if (sub && (main_stopped || idle)) begin
            run[`SIPC_RUN_T0] = 1'b0; // RULE_10
            run[`SIPC_RUN_T2] = 1'b0;
            run[`SIPC_RUN_T3] = 1'b0;
            run[`SIPC_RUN_T1] = t1_ok; // RULE_10
            bt0 = sel[`SIPC_SEL_BT0_PIN_BIT] |
                (sel[`SIPC_SEL_BT0_T1IRQ_BIT] & t1_ok);
            bt1 = sel[`SIPC_SEL_BT1_PIN_BIT] |
                (sel[`SIPC_SEL_BT1_T1IRQ_BIT] & t1_ok);
            run[`SIPC_RUN_BT0] = bt0; // RULE_11
            run[`SIPC_RUN_BT1] = bt1; // RULE_11
            run[`SIPC_RUN_IT1] = sel[`SIPC_SEL_IT1_SUBCLK_BIT]; // RULE_12
            run[`SIPC_RUN_WD2] = sel[`SIPC_SEL_WD2_SUBCLK_BIT]; // RULE_12
            run[`SIPC_RUN_CS0] = sel[`SIPC_SEL_CS0_EXT_BIT]; // RULE_13
            run[`SIPC_RUN_CS1] = sel[`SIPC_SEL_CS1_EXT_BIT]; // RULE_13
            run[`SIPC_RUN_AS0] = sel[`SIPC_SEL_AS0_PIN_BIT]; // RULE_14
            run[`SIPC_RUN_AS12] = 1'b0; // RULE_14
            run[`SIPC_RUN_RTO] = sel[`SIPC_SEL_RTO_BT_BIT] &
                (sel[`SIPC_SEL_RTO_WHICH_BIT] ?
                 sel[`SIPC_SEL_BT1_PIN_BIT] :
                 sel[`SIPC_SEL_BT0_PIN_BIT]); // RULE_15
            run[`SIPC_RUN_TP] = 1'b0; // RULE_16
            run[`SIPC_RUN_IT0] = 1'b0;
            run[`SIPC_RUN_ATS] = 1'b0;
            run[`SIPC_RUN_TWS] = 1'b0;
            run[`SIPC_RUN_ADC] = 1'b0;
        end else begin
            bt0 = 1'b1;
            bt1 = 1'b1;
        end
        // watch timer only constrained when main clock is stopped
        if (sub && main_stopped) begin
            run[`SIPC_RUN_WT] = sel[`SIPC_SEL_WT_SUBCLK_BIT]; // RULE_12
        end
        // sub-idle withholds cpu-side clocks; oscillator stays on
        if (idle) begin
            run[`SIPC_RUN_CPU] = 1'b0; // RULE_03
            run[`SIPC_RUN_INTC] = 1'b0; // RULE_03
            run[`SIPC_RUN_DMA] = 1'b0; // RULE_04
            run[`SIPC_RUN_EBI] = 1'b0; // RULE_04
        end
    end
endmodule // sipc_run_decode

// ===== hw/sipc_top.v
`include "sipc_defines.vh"
// Operation
// (RULE_01) subclock bit switches clock; stop bit halts oscillator
// (RULE_02) sub-idle only from subclock, mode zero, trigger
// (RULE_03) sub-idle gates cpu clocks, oscillator keeps running
// (RULE_04) subclock or external-clocked units keep running
// (RULE_05) software follows trigger store with five no-ops
// (RULE_06) listed interrupts and resets end sub-idle
// (RULE_07) interrupt returns subclock mode, reset returns normal
// (RULE_08) lower priority wakes but stays pending
// (RULE_09) disabled interrupts never end sub-idle
// (RULE_10) sixteen-bit timers halt except gated timer one
// (RULE_11) byte timers run on pin or timer-one irq
// (RULE_12) interval timer one, watch, watchdog two need subclock; watch runs ungated unless the main clock is stopped
// (RULE_13) clocked serial ports need external serial clock
// (RULE_14) async zero needs baud pin, others stopped
// (RULE_15) real-time output needs pin-clocked byte timer trigger
// (RULE_16) remaining main-clocked units stop; watchdog one off
// (RULE_17) cpu, dma, key, dac, regulator keep running; cpu, intc, dma and ebi are gated in sub-idle
module sipc_top (
    input wire clk,
    input wire reset,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire nmi_pin,
    input wire reset_pin,
    input wire watchdog_two_irq,
    input wire watchdog_two_reset,
    input wire [7:0] external_pin_irqs,
    input wire [7:0] external_pin_irq_mask,
    input wire [7:0] periph_irqs,
    input wire [7:0] periph_irq_mask,
    input wire [`SIPC_PRIO_W-1:0] wake_irq_prio,
    input wire [`SIPC_PRIO_W-1:0] current_prio,
    input wire in_service,
    output reg subclock_active,
    output reg main_osc_enable,
    output reg subclock_osc_enable,
    output reg [`SIPC_RUN_W-1:0] unit_run,
    output reg cpu_halted,
    output reg wake_ack,
    output reg wake_pending,
    output reg [1:0] mode_out,
    output reg sys_reset_req
);
    ////////////////////////////////////////////////////////////////
    // wake input synchronisers
    wire [17:0] wake_async;
    wire [17:0] wake_sync;
    wire nmi_s;
    wire rstpin_s;
    wire wd2irq_s;
    wire wd2rst_s;
    wire [7:0] ext_s;

    assign wake_async = {nmi_pin, reset_pin, watchdog_two_irq,
        watchdog_two_reset, external_pin_irqs, 6'h00};

    sipc_sync2 #(.W(18)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in(wake_async),
        .sync_out(wake_sync)
    );

    assign nmi_s = wake_sync[17];
    assign rstpin_s = wake_sync[16];
    assign wd2irq_s = wake_sync[15];
    assign wd2rst_s = wake_sync[14];
    assign ext_s = wake_sync[13:6];

    ////////////////////////////////////////////////////////////////
    // software registers
    reg [1:0] clk_ctrl_q;
    reg psm_q;
    reg [3:1] irq_dis_q;
    reg [`SIPC_SEL_W-1:0] clk_sel_q;
    reg [1:0] mode_q;
    reg [1:0] mode_d;
    reg [2:0] nop_cnt_q;
    reg trig_q;
    reg wr_done_q;
    reg rd_done_q;

    wire wr_req;
    wire rd_req;
    wire wr_take;
    wire trig_wr;
    wire on_sub;
    wire main_stopped;

    // one wait state per access: answer on the second edge
    assign wr_req = avs_write & ~wr_done_q;
    assign rd_req = avs_read & ~rd_done_q;
    // writes land only at the edge that ends the transfer
    assign wr_take = avs_write & ~avs_waitrequest;
    assign trig_wr = wr_take && avs_address == `SIPC_ADDR_PWR_CTRL &&
        avs_writedata[`SIPC_STANDBY_TRIGGER_BIT];
    assign on_sub = clk_ctrl_q[`SIPC_SUBCLK_SELECT_BIT];
    assign main_stopped = clk_ctrl_q[`SIPC_MAIN_OSC_STOP_BIT];

    ////////////////////////////////////////////////////////////////
    // wake decoding
    wire nmi_wake;
    wire wd2_wake;
    wire mask_wake;
    wire irq_wake;
    wire rst_wake;
    wire hi_prio;

    // disabled sources are dropped before they can wake
    assign nmi_wake = nmi_s & ~irq_dis_q[`SIPC_IRQ_DIS_NMI_BIT]; // RULE_09
    assign wd2_wake = wd2irq_s & on_sub &
        ~irq_dis_q[`SIPC_IRQ_DIS_WD2_BIT]; // RULE_09
    assign mask_wake = (|(ext_s & ~external_pin_irq_mask) |
        |(periph_irqs & ~periph_irq_mask)) &
        ~irq_dis_q[`SIPC_IRQ_DIS_MASKABLE_BIT]; // RULE_09
    assign irq_wake = nmi_wake | wd2_wake | mask_wake; // RULE_06
    assign rst_wake = rstpin_s | (wd2rst_s & on_sub); // RULE_06
    // nmi counts as higher priority than any service in progress
    assign hi_prio = nmi_wake | ~in_service |
        (wake_irq_prio < current_prio); // RULE_08

    ////////////////////////////////////////////////////////////////
    // mode state machine
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            `SIPC_MODE_NORMAL: begin
                if (on_sub) begin
                    mode_d = `SIPC_MODE_SUB; // RULE_01
                end
            end
            `SIPC_MODE_SUB: begin
                if (!on_sub) begin
                    mode_d = `SIPC_MODE_NORMAL;
                end else if (trig_q && nop_cnt_q == 3'h0) begin
                    mode_d = `SIPC_MODE_SUBIDLE; // RULE_02
                end
            end
            `SIPC_MODE_SUBIDLE: begin
                if (irq_wake) begin
                    mode_d = `SIPC_MODE_SUB; // RULE_07
                end
            end
            default: begin
                mode_d = `SIPC_MODE_NORMAL;
            end
        endcase
    end

    // reset from a wake source returns to normal operation
    always @(posedge clk) begin
        if (reset || rst_wake) begin
            mode_q <= `SIPC_MODE_NORMAL; // RULE_07
            clk_ctrl_q <= `SIPC_CLK_CTRL_RST;
            psm_q <= 1'b0;
            irq_dis_q <= 3'h0;
            clk_sel_q <= `SIPC_CLK_SEL_RST;
            trig_q <= 1'b0;
            nop_cnt_q <= 3'h0;
        end else begin
            mode_q <= mode_d;
            // trigger counts down the no-op slots before gating
            if (trig_wr && mode_q == `SIPC_MODE_SUB && !psm_q) begin
                trig_q <= 1'b1; // RULE_02
                nop_cnt_q <= `SIPC_ENTRY_NOPS; // RULE_05
            end else if (mode_q != `SIPC_MODE_SUB) begin
                trig_q <= 1'b0;
            end else if (nop_cnt_q != 3'h0) begin
                nop_cnt_q <= nop_cnt_q - 3'h1;
            end
            if (wr_take) begin
                case (avs_address)
                    `SIPC_ADDR_CLK_CTRL: begin
                        clk_ctrl_q <= avs_writedata[1:0]; // RULE_01
                    end
                    `SIPC_ADDR_PWR_MODE: begin
                        psm_q <= avs_writedata[`SIPC_PSM_SELECT_BIT];
                    end
                    `SIPC_ADDR_PWR_CTRL: begin
                        irq_dis_q <= avs_writedata[3:1];
                    end
                    `SIPC_ADDR_CLK_SEL: begin
                        clk_sel_q <= avs_writedata[`SIPC_SEL_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus answer
    always @(posedge clk) begin
        if (reset) begin
            wr_done_q <= 1'b0;
            rd_done_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            wr_done_q <= wr_req;
            rd_done_q <= rd_req;
            avs_waitrequest <= ~(wr_req | rd_req);
            if (rd_req) begin
                case (avs_address)
                    `SIPC_ADDR_CLK_CTRL:
                        avs_readdata <= {30'h0, clk_ctrl_q};
                    `SIPC_ADDR_PWR_MODE:
                        avs_readdata <= {31'h0, psm_q};
                    `SIPC_ADDR_PWR_CTRL:
                        avs_readdata <= {28'h0, irq_dis_q, trig_q};
                    `SIPC_ADDR_CLK_SEL:
                        avs_readdata <= {19'h0, clk_sel_q};
                    `SIPC_ADDR_STATUS:
                        avs_readdata <= {30'h0, mode_q};
                    `SIPC_ADDR_RUN_MASK:
                        avs_readdata <= {5'h0, unit_run};
                    default:
                        avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // unit run enables
    wire [`SIPC_RUN_W-1:0] run_d;

    sipc_run_decode u_run (
        .mode(mode_q),
        .main_stopped(main_stopped),
        .sel(clk_sel_q),
        .run(run_d)
    );

    // registered outputs; each lags its source by one edge
    always @(posedge clk) begin
        if (reset) begin
            unit_run <= {`SIPC_RUN_W{1'b1}};
            subclock_active <= 1'b0;
            main_osc_enable <= 1'b1;
            subclock_osc_enable <= 1'b1;
            cpu_halted <= 1'b0;
            wake_ack <= 1'b0;
            wake_pending <= 1'b0;
            mode_out <= `SIPC_MODE_NORMAL;
            sys_reset_req <= 1'b0;
        end else begin
            unit_run <= run_d; // RULE_04
            subclock_active <= mode_q != `SIPC_MODE_NORMAL; // RULE_01
            // stop only once running from the subclock, never from normal
            main_osc_enable <= ~(main_stopped &&
                mode_q != `SIPC_MODE_NORMAL); // RULE_01
            subclock_osc_enable <= 1'b1; // RULE_03
            cpu_halted <= mode_q == `SIPC_MODE_SUBIDLE; // RULE_03
            mode_out <= mode_q;
            sys_reset_req <= rst_wake;
            // low-priority waker stays pending until its request drops
            if (mode_q == `SIPC_MODE_SUBIDLE && irq_wake) begin
                wake_ack <= hi_prio; // RULE_08
                if (!hi_prio) begin
                    wake_pending <= 1'b1; // RULE_08
                end
            end else begin
                wake_ack <= 1'b0;
                if (!irq_wake) begin
                    wake_pending <= 1'b0;
                end
            end
        end
    end
endmodule // sipc_top

// ===== verif/sipc_properties.sv
`include "sipc_defines.vh"
// observes mode, clock gating, wake ack/pending and priority signals
module sipc_properties (
    input wire clk,
    input wire reset,
    input wire [`SIPC_PRIO_W-1:0] wake_irq_prio,
    input wire [`SIPC_PRIO_W-1:0] current_prio,
    input wire in_service,
    input wire subclock_active,
    input wire main_osc_enable,
    input wire [`SIPC_RUN_W-1:0] unit_run,
    input wire cpu_halted,
    input wire wake_ack,
    input wire wake_pending,
    input wire [1:0] mode_out
);
    localparam [1:0] SUB = `SIPC_MODE_SUB;
    localparam [1:0] IDL = `SIPC_MODE_SUBIDLE;
    reg quiet_q;
    wire quiet;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // gating lags the mode by an edge, so wait for two quiet samples
    always @(posedge clk) begin
        quiet_q <= !reset && mode_out != 2'h0 && !main_osc_enable;
    end
    assign quiet = quiet_q && mode_out != 2'h0 && !main_osc_enable;
    ////////////////////////////////////////////////////////////////////
    property p_osc;
        $fell(main_osc_enable) |-> subclock_active;
    endproperty
    a_osc: assert property (p_osc) else $error("osc stop");
    property p_entry;
        mode_out == IDL && $past(mode_out) != IDL |-> $past(mode_out) == SUB;
    endproperty
    a_entry: assert property (p_entry) else $error("idle entry");
    property p_halt;
        mode_out == IDL && $past(mode_out) == IDL
            |-> cpu_halted && !unit_run[`SIPC_RUN_CPU];
    endproperty
    a_halt: assert property (p_halt) else $error("cpu gate");
    property p_cpu;
        mode_out != IDL && $past(mode_out) != IDL
            |-> !cpu_halted && unit_run[`SIPC_RUN_CPU];
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu run");
    property p_t16;
        quiet |-> !unit_run[`SIPC_RUN_T0] && !unit_run[`SIPC_RUN_T2]
            && !unit_run[`SIPC_RUN_T3];
    endproperty
    a_t16: assert property (p_t16) else $error("timer run");
    property p_stop;
        quiet |-> !unit_run[`SIPC_RUN_TP] && !unit_run[`SIPC_RUN_ADC]
            && !unit_run[`SIPC_RUN_WD1] && !unit_run[`SIPC_RUN_IT0];
    endproperty
    a_stop: assert property (p_stop) else $error("unit run");
    property p_ack;
        wake_ack |-> !(in_service && wake_irq_prio > current_prio)
            ##1 !wake_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
    property p_pend;
        $rose(wake_pending) |-> in_service && wake_irq_prio >= current_prio;
    endproperty
    a_pend: assert property (p_pend) else $error("bad pend");
endmodule // sipc_properties

bind sipc_top sipc_properties u_props (
    .clk(clk), .reset(reset), .wake_irq_prio(wake_irq_prio),
    .current_prio(current_prio), .in_service(in_service),
    .subclock_active(subclock_active), .main_osc_enable(main_osc_enable),
    .unit_run(unit_run), .cpu_halted(cpu_halted), .wake_ack(wake_ack),
    .wake_pending(wake_pending), .mode_out(mode_out)
);

// ===== verif/testbench.sv
`include "sipc_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [5:0] src = 6'h00;
    logic [7:0] ext_mask = 8'h00;
    logic [2:0] wprio = 3'h0;
    logic [2:0] cprio = 3'h0;
    logic in_svc = 1'b0;
    logic [31:0] rnd = 32'h6516;
    logic [31:0] exp_q[$];
    wire [31:0] avs_readdata;
    wire [`SIPC_RUN_W-1:0] unit_run;
    wire [1:0] mode_out;
    wire avs_waitrequest, subclock_active, main_osc_enable, cpu_halted;
    wire wake_ack, wake_pending, sys_reset_req;
    int error_cnt = 0;
    int checks = 0;
    int ack_cnt = 0;
    int rst_cnt = 0;
    int base = 0;
    wire sub_osc;
    // src bits: nmi, wd2 irq, pin irq, periph irq, reset pin, wd2 reset
    sipc_top u_dut (
        .clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nmi_pin(src[0]),
        .watchdog_two_irq(src[1]), .reset_pin(src[4]),
        .watchdog_two_reset(src[5]), .external_pin_irqs({7'h00, src[2]}),
        .external_pin_irq_mask(ext_mask), .periph_irqs({7'h00, src[3]}),
        .periph_irq_mask(8'h00), .wake_irq_prio(wprio),
        .current_prio(cprio), .in_service(in_svc),
        .subclock_active(subclock_active), .subclock_osc_enable(sub_osc),
        .main_osc_enable(main_osc_enable), .unit_run(unit_run),
        .cpu_halted(cpu_halted), .wake_ack(wake_ack),
        .wake_pending(wake_pending), .mode_out(mode_out),
        .sys_reset_req(sys_reset_req)
    );
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    function automatic [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // run map in subclock mode with the main oscillator stopped
    function automatic [`SIPC_RUN_W-1:0] exp_run(input [12:0] s);
        logic [`SIPC_RUN_W-1:0] r;
        logic t1;
        t1 = s[0] & s[1];
        r = (1 << `SIPC_RUN_CPU) | (1 << `SIPC_RUN_INTC)
            | (1 << `SIPC_RUN_KEY) | (1 << `SIPC_RUN_DAC)
            | (1 << `SIPC_RUN_DMA) | (1 << `SIPC_RUN_EBI)
            | (1 << `SIPC_RUN_REG);
        r[`SIPC_RUN_T1] = t1;
        r[`SIPC_RUN_BT0] = s[2] | (s[3] & t1);
        r[`SIPC_RUN_BT1] = s[4] | (s[5] & t1);
        r[`SIPC_RUN_IT1] = s[6];
        r[`SIPC_RUN_WT] = s[1];
        r[`SIPC_RUN_WD2] = s[7];
        r[`SIPC_RUN_CS0] = s[8];
        r[`SIPC_RUN_CS1] = s[9];
        r[`SIPC_RUN_AS0] = s[10];
        r[`SIPC_RUN_RTO] = s[11] & (s[12] ? s[4] : s[2]);
        return r;
    endfunction
    task automatic chk(input string nm, input [31:0] seen, input [31:0] e);
        checks++;
        if (seen !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // request held until waitrequest is sampled low, then released
    task bus(input w, input [3:0] a, input [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            stop_test;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task rd(input [3:0] a, input [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task wait_mode(input [1:0] m);
        int n;
        n = 0;
        while (mode_out !== m && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("mode", mode_out, m);
        if (mode_out !== m)
            stop_test;
    endtask
    task enter(input [31:0] v);
        if (mode_out !== `SIPC_MODE_SUB) begin
            bus(1'b1, `SIPC_ADDR_CLK_CTRL, 32'h1);
            wait_mode(`SIPC_MODE_SUB);
        end
        bus(1'b1, `SIPC_ADDR_PWR_CTRL, v);
        wait_mode(`SIPC_MODE_SUBIDLE);
        repeat (2) @(posedge clk);
    endtask
    // read data checked at the edge that ends the read
    always @(posedge clk) begin
        if (wake_ack === 1'b1)
            ack_cnt <= ack_cnt + 1;
        // a watchdog reset request lasts one cycle: count it
        if (sys_reset_req === 1'b1)
            rst_cnt <= rst_cnt + 1;
        if (avs_read && avs_waitrequest === 1'b0)
            chk("readdata", avs_readdata, exp_q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("run", unit_run, {`SIPC_RUN_W{1'b1}});
        rd(4'h9, 32'h0);
        bus(1'b1, 4'h9, 32'hFFFFFFFF);
        rd(4'h9, 32'h0);
        // trigger refused in normal mode and with the mode bit set
        bus(1'b1, `SIPC_ADDR_PWR_CTRL, 32'h1);
        repeat (12) @(posedge clk);
        chk("mode", mode_out, `SIPC_MODE_NORMAL);
        bus(1'b1, `SIPC_ADDR_CLK_CTRL, 32'h1);
        wait_mode(`SIPC_MODE_SUB);
        chk("sub", subclock_active, 32'h1);
        rd(`SIPC_ADDR_STATUS, {30'h0, `SIPC_MODE_SUB});
        rd(`SIPC_ADDR_CLK_CTRL, 32'h1);
        bus(1'b1, `SIPC_ADDR_PWR_MODE, 32'h1);
        bus(1'b1, `SIPC_ADDR_PWR_CTRL, 32'h1);
        repeat (12) @(posedge clk);
        chk("mode", mode_out, `SIPC_MODE_SUB);
        bus(1'b1, `SIPC_ADDR_PWR_MODE, 32'h0);
        bus(1'b1, `SIPC_ADDR_CLK_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        chk("osc", main_osc_enable, 32'h0);
        repeat (6) begin
            rnd = lfsr(rnd);
            bus(1'b1, `SIPC_ADDR_CLK_SEL, {19'h0, rnd[12:0]});
            rd(`SIPC_ADDR_CLK_SEL, {19'h0, rnd[12:0]});
            chk("run", unit_run, exp_run(rnd[12:0]));
        end
        bus(1'b1, `SIPC_ADDR_CLK_SEL, 32'h3);
        enter(32'h1);
        chk("halt", cpu_halted, 32'h1);
        chk("sosc", sub_osc, 32'h1);
        chk("wt", unit_run[`SIPC_RUN_WT], 32'h1);
        // a masked pin must not wake
        ext_mask <= 8'hFF;
        src <= 6'h04;
        repeat (12) @(posedge clk);
        chk("mode", mode_out, `SIPC_MODE_SUBIDLE);
        ext_mask <= 8'h00;
        wait_mode(`SIPC_MODE_SUB);
        src <= 6'h00;
        // every interrupt wake, then low and high priority in a handler
        cprio <= 3'h2;
        for (int k = 0; k < 6; k++) begin
            in_svc <= k > 3;
            wprio <= (k == 4) ? 3'h5 : 3'h1;
            enter(32'h1);
            src <= 6'h01 << (k > 3 ? 2 : k);
            base = ack_cnt;
            wait_mode(`SIPC_MODE_SUB);
            // pending lasts only while the waker is still requesting
            chk("pend", wake_pending, k == 4);
            src <= 6'h00;
            repeat (4) @(posedge clk);
            chk("ack", ack_cnt - base, k != 4);
            chk("pend", wake_pending, 32'h0);
        end
        in_svc <= 1'b0;
        // disabled sources ignored; reset wakes into normal mode
        for (int k = 0; k < 4; k++) begin
            enter(32'h1 | (32'h2 << (k == 3 ? 2 : k)));
            src <= 6'h01 << k;
            repeat (12) @(posedge clk);
            chk("mode", mode_out, `SIPC_MODE_SUBIDLE);
            src <= 6'h10 << k[0];
            base = rst_cnt;
            wait_mode(`SIPC_MODE_NORMAL);
            chk("rst", rst_cnt != base, 32'h1);
            src <= 6'h00;
            repeat (6) @(posedge clk);
            rd(`SIPC_ADDR_CLK_CTRL, 32'h0);
        end
        stop_test;
    end
endmodule // testbench
